//--- verilog/usb_status_events.sv
// USB buffer status, event flags, enables and low-power handling.
`timescale 1ns/1ps
module usb_status_events
	import usb_status_pkg::*;
#(
	parameter int IDLE_LIMIT = IDLE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire txn_type txn,
	input wire err_type link_err,
	input wire logic bus_idle_pin,
	input wire logic bus_reset_pin,
	input wire logic bus_activity_pin,
	input wire logic frame_token,
	input wire logic forced_sleep_bit,
	input wire logic resume_done,
	input wire logic [2:0] endpoint_done_flags,
	input wire logic block_done,
	input wire logic half_release,
	input wire logic global_int_mask,
	input wire logic halt_mode,
	output logic control_endpoint_done_flag,
	output logic usb_irq,
	output logic wake_irq,
	output logic wait_exit,
	output logic endpoint_unavailable,
	output logic endpoint_regs_clear
);
	// -----------------------------------------------------------------
	// Synchronisers and activity gating.
	// -----------------------------------------------------------------
	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;
	logic idle_s;
	logic rst_s;
	logic act_s;
	logic run;
	logic wake_set;
	assign idle_s = pin_sync_r[0];
	assign rst_s = pin_sync_r[1];
	assign act_s = pin_sync_r[2];
	assign run = clk_en & ~halt_mode;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end else if (clk_en) begin
			pin_meta_r <= {bus_activity_pin, bus_reset_pin, bus_idle_pin};
			pin_sync_r <= pin_meta_r;
		end
	end

	// -----------------------------------------------------------------
	// Registers.
	// -----------------------------------------------------------------
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] enables_r;
	logic [7:0] info_r;
	logic [1:0] flow_r;
	logic half_idx_r;
	logic [1:0] half_state_r;
	logic [2:0] pkt_cnt_r;
	logic ctrl_done_r;
	logic idle_en_r;
	logic [31:0] idle_cnt_r;
	logic rst_seen_r;
	logic [7:0] rdata_r;

	logic good;
	logic setup_over;
	logic any_err;
	logic idle_hit;
	logic reset_rise;
	logic wr_flags;
	logic wipe;
	logic short_end;
	logic block_end;
	logic other_free;
	logic streaming;
	logic [7:0] hw_set;
	logic [7:0] buf_status;

	assign good = txn.done & ~txn.nak_or_stall & txn.pid_ok & txn.crc_ok & txn.toggle_ok
		& ~txn.overrun & ~txn.stuff_err & ~txn.frame_err;
	assign setup_over = good & txn.ep_zero & txn.is_setup & ctrl_done_r;
	assign any_err = link_err.timeout | link_err.crc | link_err.stuff | link_err.framing
		| link_err.overrun;
	assign idle_hit = idle_en_r & idle_s & (idle_cnt_r == 32'(IDLE_LIMIT));
	assign reset_rise = rst_s & ~rst_seen_r;
	assign wake_set = forced_sleep_bit & act_s;
	assign wr_flags = reg_wr & (reg_addr == ADDR_EVENT_FLAGS);
	assign wipe = reg_wr & (reg_addr == ADDR_BUF_STATUS) & reg_wdata[BIT_WIPE];
	assign streaming = (flow_r == FLOW_UPLOAD) | (flow_r == FLOW_DOWNLOAD);
	assign short_end = streaming & good & ~txn.ep_zero & (txn.endpoint == 2'h2)
		& txn.short_pkt;
	assign block_end = streaming & block_done;
	assign other_free = ~half_state_r[~half_idx_r] | half_release;
	assign hw_set = {1'b0, 1'b0, setup_over, any_err, idle_hit, wake_set,
		reset_rise, frame_token};

	// Summary flag is the OR of endpoint flags and never stored.
	assign flags_nxt = wr_flags ? ((flags_r & reg_wdata) | hw_set) : (flags_r | hw_set);
	assign buf_status = {4'h0, half_idx_r, half_state_r, 1'b0};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flags_r <= RESET_BYTE;
			enables_r <= RESET_BYTE;
			flow_r <= FLOW_NORMAL;
			rst_seen_r <= 1'b0;
		end else if (run | (clk_en & wake_set)) begin
			flags_r <= flags_nxt & EVENT_VALID_MASK & 8'h3f;
			rst_seen_r <= rst_s;
			if (reg_wr & (reg_addr == ADDR_EVENT_ENABLES)) begin
				enables_r <= reg_wdata & EVENT_VALID_MASK;
			end
			if (reset_rise) begin
				flow_r <= FLOW_NORMAL;
			end else if (short_end) begin
				flow_r <= FLOW_NORMAL;
			end else if (reg_wr & (reg_addr == ADDR_FLOW_SELECT)) begin
				flow_r <= reg_wdata[1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			half_idx_r <= 1'b0;
			half_state_r <= 2'h0;
			pkt_cnt_r <= 3'h0;
		end else if (run) begin
			if (wipe) begin
				half_idx_r <= 1'b0;
				half_state_r <= 2'h0;
				pkt_cnt_r <= 3'h0;
			end else begin
				if (half_release) begin
					half_state_r[~half_idx_r] <= 1'b0;
				end
				if (streaming & good & (txn.endpoint == 2'h2)) begin
					pkt_cnt_r <= pkt_cnt_r + 3'h1;
				end
				if (block_end) begin
					half_state_r[half_idx_r] <= 1'b1;
					if (other_free) begin
						half_idx_r <= ~half_idx_r;
						pkt_cnt_r <= 3'h0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			info_r <= RESET_BYTE;
			ctrl_done_r <= 1'b0;
		end else if (run) begin
			if (reset_rise) begin
				ctrl_done_r <= 1'b0;
			end else if (good & txn.ep_zero) begin
				ctrl_done_r <= 1'b1;
			end else if (reg_wr & (reg_addr == ADDR_TRANSFER_INFO)) begin
				ctrl_done_r <= ctrl_done_r & reg_wdata[7];
			end
			if (any_err) begin
				info_r[2:0] <= link_err.code;
			end else if (good & ~setup_over) begin
				info_r[7:3] <= {txn.pid_hi, txn.is_in, txn.endpoint};
			end else if (wr_flags & ~reg_wdata[BIT_FAULT]) begin
				info_r[2:0] <= 3'h0;
			end
		end
	end

	// -----------------------------------------------------------------
	// Idle detection.
	// -----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idle_en_r <= 1'b1;
			idle_cnt_r <= 32'h0;
		end else if (run) begin
			if (reset_rise) begin
				idle_en_r <= 1'b1;
			end else if (forced_sleep_bit) begin
				idle_en_r <= 1'b0;
			end else if (resume_done) begin
				idle_en_r <= 1'b1;
			end
			if (~idle_s | ~idle_en_r | idle_hit) begin
				idle_cnt_r <= 32'h0;
			end else begin
				idle_cnt_r <= idle_cnt_r + 32'h1;
			end
		end
	end

	// -----------------------------------------------------------------
	// Read port and outputs.
	// -----------------------------------------------------------------
	logic [7:0] flags_view;
	logic [7:0] rd_mux;
	assign flags_view = {|{endpoint_done_flags, ctrl_done_r}, flags_r[6:0]};
	assign rd_mux = (reg_addr == ADDR_BUF_STATUS) ? buf_status :
		(reg_addr == ADDR_EVENT_FLAGS) ? flags_view :
		(reg_addr == ADDR_EVENT_ENABLES) ? enables_r :
		(reg_addr == ADDR_TRANSFER_INFO) ? info_r :
		(reg_addr == ADDR_FLOW_SELECT) ? {6'h0, flow_r} : 8'h00;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (clk_en) begin
			rdata_r <= reg_rd ? rd_mux : 8'h00;
		end
	end

	logic [7:0] pend;
	assign pend = flags_view & enables_r;
	assign reg_rdata = rdata_r;
	assign control_endpoint_done_flag = ctrl_done_r;
	assign wake_irq = pend[BIT_WAKE] & ~global_int_mask;
	assign usb_irq = |(pend & ~8'h04) & ~global_int_mask;
	assign wait_exit = |pend;
	assign endpoint_unavailable = streaming & half_state_r[half_idx_r] & ~other_free;
	assign endpoint_regs_clear = reset_rise;

	// -----------------------------------------------------------------
	// Checks.
	// -----------------------------------------------------------------
	a_wipe_clears: assert property (@(posedge clk) disable iff (sys_rst)
		(wipe & run) |=> (half_state_r == 2'h0) && !half_idx_r && (pkt_cnt_r == 3'h0))
		else $error("buffer wipe failed");
	a_setup_over_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(setup_over & run) |=> flags_r[BIT_OVERWRITE]) else $error("overwrite flag missing");
	a_info_kept: assert property (@(posedge clk) disable iff (sys_rst)
		(setup_over & run & ~any_err) |=> $stable(info_r)) else $error("info changed");
	a_fault_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(any_err & run) |=> flags_r[BIT_FAULT]) else $error("fault flag missing");
	a_frame_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(frame_token & run) |=> flags_r[BIT_FRAME]) else $error("frame flag missing");
	a_no_sw_set: assert property (@(posedge clk) disable iff (sys_rst)
		(run & wr_flags & hw_set == 8'h00) |=> ((flags_r & ~$past(flags_r)) == 8'h00))
		else $error("software set a flag");
	a_short_normal: assert property (@(posedge clk) disable iff (sys_rst)
		(short_end & run & ~reset_rise) |=> (flow_r == FLOW_NORMAL))
		else $error("short packet kept stream mode");
	a_irq_gate: assert property (@(posedge clk) disable iff (sys_rst)
		global_int_mask |-> !usb_irq && !wake_irq) else $error("irq while masked");
	a_sleep_off: assert property (@(posedge clk) disable iff (sys_rst)
		(forced_sleep_bit & run & ~reset_rise) ##1 (!resume_done && !reset_rise)[*2]
		|-> !idle_en_r) else $error("idle detect on while sleeping");
	a_halt_frozen: assert property (@(posedge clk) disable iff (sys_rst)
		(halt_mode & ~wake_set) |=> $stable(enables_r) && $stable(half_state_r))
		else $error("registers moved in halt");
	a_wake_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(wake_set & clk_en) |=> flags_r[BIT_WAKE]) else $error("wake flag missing");
	a_reset_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(reset_rise & run) |=> flags_r[BIT_BUS_RESET]) else $error("bus reset flag missing");
	a_sleep_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(idle_hit & run) |=> flags_r[BIT_SLEEP]) else $error("sleep flag missing");
	a_wake_vector: assert property (@(posedge clk) disable iff (sys_rst)
		(!global_int_mask && flags_view[BIT_WAKE] && enables_r[BIT_WAKE]) |-> wake_irq)
		else $error("wake vector not raised");
	a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
		(clk_en & ~reg_rd) |=> (reg_rdata == 8'h00)) else $error("read data without read");
	a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |-> !flags_view[6] && (buf_status[7:4] == 4'h0) && !buf_status[0])
		else $error("reserved bit set");
	a_ctrl_done_set: assert property (@(posedge clk) disable iff (sys_rst)
		(good & txn.ep_zero & run & ~reset_rise) |=> ctrl_done_r)
		else $error("control done not set");
	a_nak_not_good: assert property (@(posedge clk) disable iff (sys_rst)
		txn.nak_or_stall |-> !good) else $error("refused transaction counted");
	a_bus_reset_flow: assert property (@(posedge clk) disable iff (sys_rst)
		(reset_rise & run) |=> (flow_r == FLOW_NORMAL)) else $error("flow kept after reset");
	a_block_switch: assert property (@(posedge clk) disable iff (sys_rst)
		(block_end & run & ~wipe & other_free) |=> (half_idx_r != $past(half_idx_r)))
		else $error("buffer not switched");
endmodule : usb_status_events

//--- inc/usb_status_pkg.sv
// Package of constants and types for the USB buffer status and event block.
package usb_status_pkg;
	localparam logic [2:0] ADDR_BUF_STATUS = 3'h0;
	localparam logic [2:0] ADDR_EVENT_FLAGS = 3'h1;
	localparam logic [2:0] ADDR_EVENT_ENABLES = 3'h2;
	localparam logic [2:0] ADDR_TRANSFER_INFO = 3'h3;
	localparam logic [2:0] ADDR_FLOW_SELECT = 3'h4;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] EVENT_VALID_MASK = 8'hbf;
	localparam int BIT_WIPE = 0;
	localparam int BIT_GOOD = 7;
	localparam int BIT_OVERWRITE = 5;
	localparam int BIT_FAULT = 4;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_WAKE = 2;
	localparam int BIT_BUS_RESET = 1;
	localparam int BIT_FRAME = 0;
	localparam logic [1:0] FLOW_NORMAL = 2'h0;
	localparam logic [1:0] FLOW_UPLOAD = 2'h1;
	localparam logic [1:0] FLOW_DOWNLOAD = 2'h2;
	localparam int IDLE_TIME_US = 3000;
	localparam int CLK_MHZ = 125;
	localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
	localparam int PACKETS_PER_BLOCK = 8;
	typedef struct packed {
		logic done;
		logic ep_zero;
		logic is_setup;
		logic nak_or_stall;
		logic pid_ok;
		logic crc_ok;
		logic toggle_ok;
		logic overrun;
		logic stuff_err;
		logic frame_err;
		logic short_pkt;
		logic is_in;
		logic [1:0] endpoint;
		logic [1:0] pid_hi;
	} txn_type;
	typedef struct packed {
		logic timeout;
		logic crc;
		logic stuff;
		logic framing;
		logic overrun;
		logic [2:0] code;
	} err_type;
endpackage : usb_status_pkg

//--- tb/usb_host_model.sv
// Host-side model driving tokens, transactions, link errors and bus levels.
`timescale 1ns/1ps
module usb_host_model
	import usb_status_pkg::*;
(
	input wire logic clk,
	output txn_type txn,
	output err_type link_err,
	output logic frame_token,
	output logic bus_idle_pin,
	output logic bus_reset_pin,
	output logic bus_activity_pin
);
	initial begin
		txn = '0;
		link_err = '0;
		frame_token = 1'b0;
		bus_idle_pin = 1'b0;
		bus_reset_pin = 1'b0;
		bus_activity_pin = 1'b0;
	end
	task automatic frame();
		@(posedge clk) frame_token <= 1'b1;
		@(posedge clk) frame_token <= 1'b0;
	endtask : frame
	// One transaction; a handshake of NAK or STALL marks it refused.
	task automatic xact(input logic setup, input logic nak, input logic shrt,
		input logic [1:0] ep);
		txn_type t;
		t = '0;
		t.done = 1'b1;
		t.ep_zero = (ep == 2'h0);
		t.is_setup = setup;
		t.nak_or_stall = nak;
		t.pid_ok = 1'b1;
		t.crc_ok = 1'b1;
		t.toggle_ok = 1'b1;
		t.short_pkt = shrt;
		t.endpoint = ep;
		t.pid_hi = setup ? 2'h3 : 2'h0;
		@(posedge clk) txn <= t;
		@(posedge clk) txn <= '0;
	endtask : xact
	task automatic crc_fault();
		@(posedge clk) link_err <= '{crc: 1'b1, code: 3'h2, default: 1'b0};
		@(posedge clk) link_err <= '0;
	endtask : crc_fault
	// Levels pass a two-flop synchroniser, so settle before returning.
	task automatic pins(input logic idle, input logic rst, input logic act);
		@(posedge clk);
		bus_idle_pin <= idle;
		bus_reset_pin <= rst;
		bus_activity_pin <= act;
		repeat (4) @(posedge clk);
	endtask : pins
endmodule : usb_host_model

//--- tb/tb_usb_buffer_status_and_events.sv
// Self-checking bench for the USB buffer status and event block.
`timescale 1ns/1ps
module tb_usb_buffer_status_and_events import usb_status_pkg::*; ;
	logic clk, sys_rst, reg_wr, reg_rd, fsleep, bdone, gmask, halt;
	logic [2:0] reg_addr, epd;
	logic [7:0] reg_wdata, reg_rdata;
	txn_type txn;
	err_type lerr;
	logic frm, idle, brst, act, ctl_done, usb_irq, wake_irq, wexit;
	int num_errors = 0;
	int comparisons = 0;
	usb_host_model host (.clk(clk), .txn(txn), .link_err(lerr), .frame_token(frm),
		.bus_idle_pin(idle), .bus_reset_pin(brst), .bus_activity_pin(act));
	usb_status_events #(.IDLE_LIMIT(20)) uut (.clk(clk), .sys_rst(sys_rst),
		.clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .txn(txn), .link_err(lerr),
		.bus_idle_pin(idle), .bus_reset_pin(brst), .bus_activity_pin(act),
		.frame_token(frm), .forced_sleep_bit(fsleep), .resume_done(1'b0),
		.endpoint_done_flags(epd), .block_done(bdone), .half_release(1'b0),
		.global_int_mask(gmask), .halt_mode(halt),
		.control_endpoint_done_flag(ctl_done), .usb_irq(usb_irq),
		.wake_irq(wake_irq), .wait_exit(wexit), .endpoint_unavailable(),
		.endpoint_regs_clear());
	// --------------------------------------------------------------
	// Clock, bus tasks and verdict.
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk) reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk) reg_rd <= 1'b0;
		#1 cmp(reg_rdata, exp);
	endtask : rd
	task automatic end_of_test();
		if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
	// --------------------------------------------------------------
	// Test sequence.
	// --------------------------------------------------------------
	initial begin
		{sys_rst, reg_wr, reg_rd, fsleep, bdone, gmask, halt} = 7'h40;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		epd = 3'h0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 6; a++) rd(3'(a), 8'h00);
		wr(ADDR_EVENT_ENABLES, 8'hff);
		rd(ADDR_EVENT_ENABLES, 8'hbf);
		host.frame();
		rd(ADDR_EVENT_FLAGS, 8'h01);
		cmp({7'h0, usb_irq}, 8'h01);
		cmp({7'h0, wexit}, 8'h01);
		@(posedge clk) gmask <= 1'b1;
		@(posedge clk) #1 cmp({7'h0, usb_irq}, 8'h00);
		gmask <= 1'b0;
		wr(ADDR_EVENT_FLAGS, 8'hff);
		rd(ADDR_EVENT_FLAGS, 8'h01);
		wr(ADDR_EVENT_FLAGS, 8'hfe);
		rd(ADDR_EVENT_FLAGS, 8'h00);
		wr(ADDR_EVENT_FLAGS, 8'hff);
		rd(ADDR_EVENT_FLAGS, 8'h00);
		@(posedge clk) halt <= 1'b1;
		host.frame();
		@(posedge clk) halt <= 1'b0;
		rd(ADDR_EVENT_FLAGS, 8'h00);
		host.xact(1'b0, 1'b1, 1'b0, 2'h0);
		rd(ADDR_EVENT_FLAGS, 8'h00);
		host.xact(1'b0, 1'b0, 1'b0, 2'h0);
		rd(ADDR_EVENT_FLAGS, 8'h80);
		cmp({7'h0, ctl_done}, 8'h01);
		host.xact(1'b1, 1'b0, 1'b0, 2'h0);
		rd(ADDR_EVENT_FLAGS, 8'ha0);
		wr(ADDR_TRANSFER_INFO, 8'h00);
		wr(ADDR_EVENT_FLAGS, 8'h00);
		rd(ADDR_EVENT_FLAGS, 8'h00);
		epd <= 3'h2;
		wr(ADDR_EVENT_FLAGS, 8'h00);
		rd(ADDR_EVENT_FLAGS, 8'h80);
		epd <= 3'h0;
		host.crc_fault();
		rd(ADDR_EVENT_FLAGS, 8'h10);
		wr(ADDR_EVENT_FLAGS, 8'h00);
		wr(ADDR_FLOW_SELECT, FLOW_DOWNLOAD);
		rd(ADDR_FLOW_SELECT, 8'h02);
		wr(ADDR_FLOW_SELECT, FLOW_UPLOAD);
		rd(ADDR_FLOW_SELECT, 8'h01);
		@(posedge clk) bdone <= 1'b1;
		@(posedge clk) bdone <= 1'b0;
		rd(ADDR_BUF_STATUS, 8'h0a);
		wr(ADDR_BUF_STATUS, 8'hf1);
		rd(ADDR_BUF_STATUS, 8'h00);
		host.xact(1'b0, 1'b0, 1'b1, 2'h2);
		rd(ADDR_FLOW_SELECT, 8'h00);
		wr(ADDR_FLOW_SELECT, FLOW_UPLOAD);
		wr(ADDR_EVENT_FLAGS, 8'h00);
		host.pins(1'b0, 1'b1, 1'b0);
		rd(ADDR_EVENT_FLAGS, 8'h02);
		rd(ADDR_FLOW_SELECT, 8'h00);
		host.pins(1'b0, 1'b0, 1'b0);
		wr(ADDR_EVENT_FLAGS, 8'h00);
		host.pins(1'b1, 1'b0, 1'b0);
		repeat (30) @(posedge clk);
		rd(ADDR_EVENT_FLAGS, 8'h08);
		host.pins(1'b0, 1'b0, 1'b0);
		wr(ADDR_EVENT_FLAGS, 8'h00);
		fsleep <= 1'b1;
		host.pins(1'b1, 1'b0, 1'b0);
		repeat (30) @(posedge clk);
		rd(ADDR_EVENT_FLAGS, 8'h00);
		host.pins(1'b0, 1'b0, 1'b1);
		rd(ADDR_EVENT_FLAGS, 8'h04);
		cmp({7'h0, wake_irq}, 8'h01);
		cmp({7'h0, usb_irq}, 8'h00);
		end_of_test();
	end
endmodule : tb_usb_buffer_status_and_events
